// [rtl/errrec_top.sv]
// Error record register bank: address, control, feature and syndrome registers.
// Assumes a same-clock system-register port and same-clock error reports.
`timescale 1ns/10ps
module errrec_top #(
    parameter int SEL_W = errrec_pkg::SEL_W
) (
    // Clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      rst,

    // Selected-record register access
    input  wire logic [SEL_W-1:0]          record_index_choice,
    input  wire logic                      reg_req,
    input  wire logic                      reg_write,
    input  wire logic [2:0]                reg_id,
    input  wire logic [63:0]               reg_wdata,
    output logic [63:0]                    reg_rdata,
    output logic                           reg_ack,

    // Error report from detection logic
    input  wire logic                      err_valid,
    input  wire errrec_pkg::errrec_kind_t  err_kind,
    input  wire logic                      err_higher_prio,
    input  wire logic [47:0]               err_paddr,
    input  wire logic                      err_nonsecure,
    input  wire logic [31:0]               err_location,

    // Controls and interrupts
    output logic                           error_detection_enable,
    output logic                           fault_irq,
    output logic                           recovery_irq
);
    // Register state
    logic [47:0] paddr_q;
    logic [47:0] paddr_d;
    logic        secure_state_bit_q;
    logic        secure_state_bit_d;
    logic        ed_q;
    logic        ed_d;
    logic        ui_q;
    logic        ui_d;
    logic        fi_q;
    logic        fi_d;
    logic        cfi_q;
    logic        cfi_d;
    logic [31:0] loc_q;
    logic [31:0] loc_d;
    logic        held_q;
    logic        held_d;
    logic [63:0] rdata_q;
    logic [63:0] rdata_d;
    logic        ack_q;
    logic        fault_pulse_q;
    logic        recov_pulse_q;

    // Access decode
    logic        this_rec;
    logic        wr_addr;
    logic        wr_ctl;
    logic        wr_misc0;
    logic        rd_go;

    // Event actions
    logic        rep_inc;
    logic        oth_inc;
    logic        syn_load;
    logic        addr_load;
    logic        fault_evt;
    logic        recov_evt;
    logic        syn_match;

    // Counters
    logic [6:0]  repeat_corrected_count;
    logic        repeat_overflow_sticky;
    logic [6:0]  other_corrected_count;
    logic        other_overflow_sticky;

    // Read views
    logic [63:0] addr_view;
    logic [63:0] ctl_view;
    logic [63:0] feat_view;
    logic [63:0] misc0_view;

    // Feature fields
    logic [1:0]  deferred_recovery_irq_support;
    logic        repeat_counter_present;
    logic [2:0]  corrected_counter_kind;
    logic [1:0]  feat_cfi;
    logic [1:0]  inband_error_report;
    logic [1:0]  feat_fi;
    logic [1:0]  feat_ui;
    logic [1:0]  feat_ed;

    localparam logic [SEL_W-1:0] SEL_THIS_W = SEL_W'(errrec_pkg::SEL_THIS);

    // Decoding of the selected-record access
    assign this_rec = record_index_choice == SEL_THIS_W;
    assign wr_addr  = reg_req & reg_write & this_rec & (reg_id == errrec_pkg::ID_ADDR);
    assign wr_ctl   = reg_req & reg_write & this_rec & (reg_id == errrec_pkg::ID_CTL);
    assign wr_misc0 = reg_req & reg_write & this_rec & (reg_id == errrec_pkg::ID_MISC0);
    assign rd_go    = reg_req & ~reg_write;

    // Event sorting
    assign syn_match = (err_location & errrec_pkg::LOC_MASK) == loc_q;

    errrec_event_sort u_sort (
        .err_valid       (err_valid),
        .err_kind        (err_kind),
        .err_higher_prio (err_higher_prio),
        .ed              (ed_q),
        .fi              (fi_q),
        .ui              (ui_q),
        .held            (held_q),
        .syn_match       (syn_match),
        .rep_inc         (rep_inc),
        .oth_inc         (oth_inc),
        .syn_load        (syn_load),
        .addr_load       (addr_load),
        .fault_evt       (fault_evt),
        .recov_evt       (recov_evt)
    );

    // Counters count even when a higher priority error blocks the record
    errrec_counter #(
        .W (errrec_pkg::CNT_W)
    ) u_rep (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .inc      (rep_inc),
        .wr_en    (wr_misc0),
        .wr_count (reg_wdata[errrec_pkg::REP_LSB +: errrec_pkg::CNT_W]),
        .wr_flag  (reg_wdata[errrec_pkg::REP_OVF_BIT]),
        .count    (repeat_corrected_count),
        .ovf      (repeat_overflow_sticky)
    );

    errrec_counter #(
        .W (errrec_pkg::CNT_W)
    ) u_oth (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .inc      (oth_inc),
        .wr_en    (wr_misc0),
        .wr_count (reg_wdata[errrec_pkg::OTH_LSB +: errrec_pkg::CNT_W]),
        .wr_flag  (reg_wdata[errrec_pkg::OTH_OVF_BIT]),
        .count    (other_corrected_count),
        .ovf      (other_overflow_sticky)
    );

    // Address record next value, hardware capture wins over software
    assign paddr_d = addr_load ? err_paddr
                   : (wr_addr ? reg_wdata[errrec_pkg::PA_W-1:0] : paddr_q);
    assign secure_state_bit_d = addr_load ? err_nonsecure
                   : (wr_addr ? reg_wdata[errrec_pkg::NS_BIT] : secure_state_bit_q);

    // Control next values
    assign ed_d  = wr_ctl ? reg_wdata[errrec_pkg::CTL_ED_BIT]  : ed_q;
    assign ui_d  = wr_ctl ? reg_wdata[errrec_pkg::CTL_UI_BIT]  : ui_q;
    assign fi_d  = wr_ctl ? reg_wdata[errrec_pkg::CTL_FI_BIT]  : fi_q;
    assign cfi_d = wr_ctl ? reg_wdata[errrec_pkg::CTL_CFI_BIT] : cfi_q;

    // Syndrome location, captured with the first recorded corrected error
    assign loc_d = syn_load ? (err_location & errrec_pkg::LOC_MASK)
                 : (wr_misc0 ? (reg_wdata[31:0] & errrec_pkg::LOC_MASK) : loc_q);
    assign held_d = syn_load | (held_q & ~wr_misc0);

    // Feature fields
    assign deferred_recovery_irq_support = errrec_pkg::FR_DUI;
    assign repeat_counter_present        = errrec_pkg::FR_RP;
    assign corrected_counter_kind        = errrec_pkg::FR_CEC;
    assign feat_cfi                      = errrec_pkg::FR_CFI;
    assign inband_error_report           = errrec_pkg::FR_UE;
    assign feat_fi                       = errrec_pkg::FR_FI;
    assign feat_ui                       = errrec_pkg::FR_UI;
    assign feat_ed                       = errrec_pkg::FR_ED;

    assign feat_view = {46'h0, deferred_recovery_irq_support, repeat_counter_present,
                        corrected_counter_kind, feat_cfi, inband_error_report,
                        feat_fi, feat_ui, 2'h0, feat_ed};

    // Read views
    assign addr_view = {secure_state_bit_q, 15'h0, paddr_q};
    assign ctl_view  = {55'h0, cfi_q, 4'h0, fi_q, ui_q, 1'h0, ed_q};
    assign misc0_view = {16'h0, other_overflow_sticky, other_corrected_count,
                         repeat_overflow_sticky, repeat_corrected_count,
                         loc_q};

    assign rdata_d = ~this_rec                       ? 64'h0
                   : (reg_id == errrec_pkg::ID_ADDR)  ? addr_view
                   : (reg_id == errrec_pkg::ID_CTL)   ? ctl_view
                   : (reg_id == errrec_pkg::ID_FEAT)  ? feat_view
                   : (reg_id == errrec_pkg::ID_MISC0) ? misc0_view
                   : 64'h0;

    // Address and syndrome storage
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            paddr_q            <= '0;
            secure_state_bit_q <= 1'b0;
            loc_q              <= '0;
            held_q             <= 1'b0;
        end else begin
            paddr_q            <= paddr_d;
            secure_state_bit_q <= secure_state_bit_d;
            loc_q              <= loc_d;
            held_q             <= held_d;
        end
    end

    // Control storage
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ed_q  <= errrec_pkg::CTL_RST;
            ui_q  <= errrec_pkg::CTL_RST;
            fi_q  <= errrec_pkg::CTL_RST;
            cfi_q <= errrec_pkg::CTL_RST;
        end else begin
            ed_q  <= ed_d;
            ui_q  <= ui_d;
            fi_q  <= fi_d;
            cfi_q <= cfi_d;
        end
    end

    // Read answer, one cycle after each accepted request
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_q <= '0;
            ack_q   <= 1'b0;
        end else begin
            rdata_q <= rd_go ? rdata_d : rdata_q;
            ack_q   <= reg_req;
        end
    end

    // Event interrupt pulses
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fault_pulse_q <= 1'b0;
            recov_pulse_q <= 1'b0;
        end else begin
            fault_pulse_q <= fault_evt;
            recov_pulse_q <= recov_evt;
        end
    end

    // Outputs
    assign reg_rdata = rdata_q;
    assign reg_ack   = ack_q;
    assign error_detection_enable = ed_q;
    assign fault_irq = (cfi_q & (repeat_overflow_sticky | other_overflow_sticky))
                     | fault_pulse_q;
    assign recovery_irq = recov_pulse_q;
endmodule : errrec_top

// [rtl/errrec_pkg.sv]
// Constants, field layouts and types for the error record register bank.
// Assumes one core clock and a selected-record system-register access port.
package errrec_pkg;
    localparam int DATA_W       = 64;
    localparam int PA_W         = 48;
    localparam int NS_BIT       = 63;
    localparam int CTL_ED_BIT   = 0;
    localparam int CTL_UI_BIT   = 2;
    localparam int CTL_FI_BIT   = 3;
    localparam int CTL_CFI_BIT  = 8;
    localparam logic CTL_RST    = 1'h0;
    localparam int LOC_W        = 32;
    localparam logic [31:0] LOC_MASK = 32'hf3ff_ffff;
    localparam int CNT_W        = 7;
    localparam int REP_LSB      = 32;
    localparam int REP_OVF_BIT  = 39;
    localparam int OTH_LSB      = 40;
    localparam int OTH_OVF_BIT  = 47;
    localparam int SEL_W        = 16;
    localparam logic [15:0] SEL_THIS = 16'h0000;
    localparam int REG_ID_W     = 3;
    localparam logic [2:0] ID_ADDR  = 3'h0;
    localparam logic [2:0] ID_CTL   = 3'h1;
    localparam logic [2:0] ID_FEAT  = 3'h2;
    localparam logic [2:0] ID_MISC0 = 3'h3;
    localparam logic [2:0] ID_MISC1 = 3'h4;
    localparam logic [1:0] FR_DUI   = 2'h0;
    localparam logic       FR_RP    = 1'h1;
    localparam logic [2:0] FR_CEC   = 3'h2;
    localparam logic [1:0] FR_CFI   = 2'h2;
    localparam logic [1:0] FR_UE    = 2'h1;
    localparam logic [1:0] FR_FI    = 2'h2;
    localparam logic [1:0] FR_UI    = 2'h2;
    localparam logic [1:0] FR_ED    = 2'h2;
    localparam logic [63:0] FR_VALUE = 64'h0000_0000_0000_a9a2;
    typedef enum logic [1:0] {
        KIND_CORR   = 2'h0,
        KIND_DEFER  = 2'h1,
        KIND_UNCORR = 2'h3,
        KIND_NONE   = 2'h2
    } errrec_kind_t;
endpackage : errrec_pkg

// [rtl/errrec_counter.sv]
// Corrected-error counter with a sticky overflow flag.
// Assumes increment and software write are same-clock single-cycle strobes.
`timescale 1ns/10ps
module errrec_counter #(
    parameter int W = 7
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // Hardware event
    input  wire logic         inc,
    // Software write
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_count,
    input  wire logic         wr_flag,
    // State
    output logic [W-1:0]      count,
    output logic              ovf
);
    logic [W-1:0] count_q;
    logic [W-1:0] count_d;
    logic         ovf_q;
    logic         ovf_d;
    logic         wrap;

    assign wrap    = inc & (&count_q);
    assign count_d = inc ? count_q + W'(1) : (wr_en ? wr_count : count_q);
    assign ovf_d   = wrap | (wr_en ? wr_flag : ovf_q);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count_q <= '0;
            ovf_q   <= 1'b0;
        end else begin
            count_q <= count_d;
            ovf_q   <= ovf_d;
        end
    end

    assign count = count_q;
    assign ovf   = ovf_q;
endmodule : errrec_counter

// [rtl/errrec_event_sort.sv]
// Sorts one reported error into counter, record and interrupt actions.
// Assumes event inputs come from same-clock detection logic.
`timescale 1ns/10ps
module errrec_event_sort (
    // Reported error
    input  wire logic                      err_valid,
    input  wire errrec_pkg::errrec_kind_t  err_kind,
    input  wire logic                      err_higher_prio,
    // Record state
    input  wire logic                      ed,
    input  wire logic                      fi,
    input  wire logic                      ui,
    input  wire logic                      held,
    input  wire logic                      syn_match,
    // Actions
    output logic                           rep_inc,
    output logic                           oth_inc,
    output logic                           syn_load,
    output logic                           addr_load,
    output logic                           fault_evt,
    output logic                           recov_evt
);
    logic accept;
    logic is_corr;
    logic is_defer;
    logic is_uncorr;

    assign accept    = err_valid & ed;
    assign is_corr   = err_kind == errrec_pkg::KIND_CORR;
    assign is_defer  = err_kind == errrec_pkg::KIND_DEFER;
    assign is_uncorr = err_kind == errrec_pkg::KIND_UNCORR;

    assign rep_inc   = accept & is_corr & (~held | syn_match);
    assign oth_inc   = accept & is_corr & held & ~syn_match;
    assign syn_load  = accept & is_corr & ~held & ~err_higher_prio;
    assign addr_load = accept & ~err_higher_prio;
    assign fault_evt = accept & (is_defer | is_uncorr) & fi;
    assign recov_evt = accept & is_uncorr & ui;
endmodule : errrec_event_sort

// [dv/errrec_properties.sv]
// Concurrent checks on the error record register bank ports.
// Bound to errrec_top; one clock, synchronous active-high reset.
`timescale 1ns/10ps
module errrec_properties #(
    parameter int SEL_W = 16
) (
    // Clock and reset
    input wire logic                     ref_clk,
    input wire logic                     rst,
    // Register port
    input wire logic [SEL_W-1:0]         record_index_choice,
    input wire logic                     reg_req,
    input wire logic                     reg_write,
    input wire logic [2:0]               reg_id,
    input wire logic [63:0]              reg_wdata,
    input wire logic [63:0]              reg_rdata,
    input wire logic                     reg_ack,
    // Error port and outputs
    input wire logic                     err_valid,
    input wire errrec_pkg::errrec_kind_t err_kind,
    input wire logic                     error_detection_enable,
    input wire logic                     fault_irq,
    input wire logic                     recovery_irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic rd_ok;
    logic wr_ok;
    assign rd_ok = reg_req && !reg_write && record_index_choice == '0;
    assign wr_ok = reg_req && reg_write && record_index_choice == '0;

    ack_follows_req_a: assert property (reg_req |=> reg_ack)
        else $error("access not acknowledged");
    ack_has_cause_a: assert property ($rose(reg_ack) |-> $past(reg_req))
        else $error("acknowledge without request");
    other_sel_zero_a: assert property (reg_req && !reg_write && record_index_choice != '0
        |=> reg_rdata == 64'h0) else $error("unselected record returned data");
    feat_const_a: assert property (rd_ok && reg_id == errrec_pkg::ID_FEAT
        |=> reg_rdata == 64'h0000_0000_0000_a9a2) else $error("feature value wrong");
    addr_res_a: assert property (rd_ok && reg_id == errrec_pkg::ID_ADDR
        |=> reg_rdata[62:48] == 15'h0) else $error("address reserved bits set");
    ctl_res_a: assert property (rd_ok && reg_id == errrec_pkg::ID_CTL
        |=> reg_rdata[63:9] == '0 && reg_rdata[7:4] == 4'h0 && !reg_rdata[1])
        else $error("control reserved bits set");
    misc_res_a: assert property (rd_ok && reg_id == errrec_pkg::ID_MISC0
        |=> reg_rdata[63:48] == 16'h0) else $error("syndrome reserved bits set");
    ed_write_a: assert property (wr_ok && reg_id == errrec_pkg::ID_CTL
        |=> error_detection_enable == $past(reg_wdata[0])) else $error("enable not written");
    ed_reset_a: assert property ($fell(rst) |-> !error_detection_enable)
        else $error("enable set after reset");
    recov_cause_a: assert property (recovery_irq |-> $past(err_valid && error_detection_enable
        && err_kind == errrec_pkg::KIND_UNCORR)) else $error("recovery pulse without cause");
    fault_cause_a: assert property ($rose(fault_irq)
        |-> $past(err_valid && error_detection_enable || reg_req && reg_write))
        else $error("fault interrupt without cause");

    cover property (recovery_irq);
    cover property (fault_irq [*3]);
    cover property (reg_req ##1 reg_req);
endmodule : errrec_properties

bind errrec_top errrec_properties #(.SEL_W(SEL_W)) u_props (.ref_clk, .rst,
    .record_index_choice, .reg_req, .reg_write, .reg_id, .reg_wdata, .reg_rdata,
    .reg_ack, .err_valid, .err_kind, .error_detection_enable, .fault_irq, .recovery_irq);

// [dv/errrec_detect_model.sv]
// Model of the core error detection logic that reports into the record.
// Assumes the bench calls report() from one process at a time.
`timescale 1ns/10ps
module errrec_detect_model (
    // Clock
    input wire logic                 ref_clk,
    // Error report
    output logic                     err_valid,
    output errrec_pkg::errrec_kind_t err_kind,
    output logic                     err_higher_prio,
    output logic [47:0]              err_paddr,
    output logic                     err_nonsecure,
    output logic [31:0]              err_location
);
    initial begin
        err_valid = 1'b0;
        err_kind = errrec_pkg::KIND_NONE;
        err_higher_prio = 1'b0;
        err_paddr = 48'h0;
        err_nonsecure = 1'b0;
        err_location = 32'h0;
    end

    // One-cycle report; afterwards the data lines carry inverted junk
    task automatic report(input errrec_pkg::errrec_kind_t k, input logic hp,
                          input logic [47:0] pa, input logic ns, input logic [31:0] loc);
        @(posedge ref_clk);
        err_valid <= 1'b1;
        err_kind <= k;
        err_higher_prio <= hp;
        err_paddr <= pa;
        err_nonsecure <= ns;
        err_location <= loc;
        @(posedge ref_clk);
        err_valid <= 1'b0;
        err_kind <= errrec_pkg::KIND_NONE;
        err_higher_prio <= ~hp;
        err_paddr <= ~pa;
        err_nonsecure <= ~ns;
        err_location <= ~loc;
    endtask : report
endmodule : errrec_detect_model

// [dv/error_record_registers_test.sv]
// Self-checking bench for the error record register bank.
// Drives the register port itself and errors through the detection model.
`timescale 1ns/10ps
module error_record_registers_test;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] record_index_choice = 16'h0;
    logic        reg_req = 1'b0;
    logic        reg_write = 1'b0;
    logic [2:0]  reg_id = 3'h0;
    logic [63:0] reg_wdata = 64'h0;
    logic [63:0] reg_rdata;
    logic        reg_ack;
    logic        err_valid;
    logic        err_higher_prio;
    logic        err_nonsecure;
    logic [47:0] err_paddr;
    logic [31:0] err_location;
    logic        error_detection_enable;
    logic        fault_irq;
    logic        recovery_irq;
    errrec_pkg::errrec_kind_t err_kind;
    int          fail_count = 0;
    int          n_checks = 0;

    always #12.5 ref_clk = ~ref_clk;

    errrec_top uut (.ref_clk, .rst, .record_index_choice, .reg_req, .reg_write, .reg_id,
        .reg_wdata, .reg_rdata, .reg_ack, .err_valid, .err_kind, .err_higher_prio, .err_paddr,
        .err_nonsecure, .err_location, .error_detection_enable, .fault_irq, .recovery_irq);
    errrec_detect_model partner (.ref_clk, .err_valid, .err_kind, .err_higher_prio,
        .err_paddr, .err_nonsecure, .err_location);

    task automatic print_verdict();
        $display("checks %0d failures %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic acc(input logic wr, input logic [2:0] id, input logic [63:0] wd,
                       output logic [63:0] rd);
        @(posedge ref_clk);
        reg_req <= 1'b1;
        reg_write <= wr;
        reg_id <= id;
        reg_wdata <= wd;
        @(posedge ref_clk);
        reg_req <= 1'b0;
        #1;
        chk(reg_ack, 1'b1);
        rd = reg_rdata;
    endtask : acc

    task automatic ev(input errrec_pkg::errrec_kind_t k, input logic hp, input logic ns,
                      input logic [31:0] loc);
        partner.report(k, hp, 48'h1234_5678_9abc, ns, loc);
        #1;
    endtask : ev

    task automatic settle();
        @(posedge ref_clk);
        #1;
    endtask : settle

    function automatic logic [63:0] misc(input logic oo, input logic [6:0] oc, input logic ro,
                                         input logic [6:0] rc, input logic [31:0] loc);
        return {16'h0, oo, oc, ro, rc, loc};
    endfunction : misc

    task automatic t_reset();
        logic [63:0] d;
        acc(1'b0, errrec_pkg::ID_FEAT, 64'h0, d);
        chk(d, 64'h0000_0000_0000_a9a2);
        chk(d[17:16], 2'h0);
        chk(d[15], 1'h1);
        chk(d[14:12], 3'h2);
        chk(d[11:10], 2'h2);
        chk(d[9:8], 2'h1);
        chk(d[7:6], 2'h2);
        chk(d[5:4], 2'h2);
        chk(d[1:0], 2'h2);
        acc(1'b0, errrec_pkg::ID_CTL, 64'h0, d);
        chk(d, 64'h0);
        chk(error_detection_enable, 1'b0);
        acc(1'b0, errrec_pkg::ID_MISC1, 64'h0, d);
        chk(d, 64'h0);
    endtask : t_reset

    task automatic t_access();
        logic [63:0] d;
        acc(1'b1, errrec_pkg::ID_FEAT, 64'h0, d);
        acc(1'b0, errrec_pkg::ID_FEAT, 64'h0, d);
        chk(d, 64'h0000_0000_0000_a9a2);
        @(posedge ref_clk);
        record_index_choice <= 16'h0001;
        acc(1'b1, errrec_pkg::ID_CTL, '1, d);
        acc(1'b0, errrec_pkg::ID_FEAT, 64'h0, d);
        chk(d, 64'h0);
        @(posedge ref_clk);
        record_index_choice <= 16'h0000;
        acc(1'b0, errrec_pkg::ID_CTL, 64'h0, d);
        chk(d, 64'h0);
        acc(1'b1, errrec_pkg::ID_CTL, '1, d);
        acc(1'b0, errrec_pkg::ID_CTL, 64'h0, d);
        chk(d, 64'h10d);
        chk(error_detection_enable, 1'b1);
        acc(1'b1, errrec_pkg::ID_ADDR, '1, d);
        acc(1'b0, errrec_pkg::ID_ADDR, 64'h0, d);
        chk(d, 64'h8000_ffff_ffff_ffff);
        acc(1'b1, errrec_pkg::ID_MISC0, '1, d);
        acc(1'b0, errrec_pkg::ID_MISC0, 64'h0, d);
        chk(d, 64'h0000_ffff_f3ff_ffff);
        acc(1'b1, errrec_pkg::ID_MISC0, 64'h0, d);
    endtask : t_access

    task automatic t_events();
        logic [63:0] d;
        ev(errrec_pkg::KIND_CORR, 1'b0, 1'b1, 32'h1234);
        acc(1'b0, errrec_pkg::ID_ADDR, 64'h0, d);
        chk(d, 64'h8000_1234_5678_9abc);
        acc(1'b0, errrec_pkg::ID_MISC0, 64'h0, d);
        chk(d, misc(1'b0, 7'h0, 1'b0, 7'h1, 32'h1234));
        ev(errrec_pkg::KIND_CORR, 1'b0, 1'b1, 32'h1234);
        ev(errrec_pkg::KIND_CORR, 1'b0, 1'b1, 32'h5678);
        acc(1'b0, errrec_pkg::ID_MISC0, 64'h0, d);
        chk(d[47:32], 16'h0102);
        ev(errrec_pkg::KIND_UNCORR, 1'b0, 1'b0, 32'h5678);
        chk(fault_irq, 1'b1);
        chk(recovery_irq, 1'b1);
        acc(1'b0, errrec_pkg::ID_ADDR, 64'h0, d);
        chk(d[63], 1'b0);
        ev(errrec_pkg::KIND_DEFER, 1'b0, 1'b1, 32'h5678);
        chk(fault_irq, 1'b1);
        chk(recovery_irq, 1'b0);
    endtask : t_events

    task automatic t_overflow();
        logic [63:0] d;
        acc(1'b1, errrec_pkg::ID_MISC0, misc(1'b0, 7'h0, 1'b0, 7'h7f, 32'h1234), d);
        ev(errrec_pkg::KIND_CORR, 1'b0, 1'b1, 32'h1234);
        repeat (3) settle();
        chk(fault_irq, 1'b1);
        acc(1'b0, errrec_pkg::ID_MISC0, 64'h0, d);
        chk(d[47:32], 16'h0080);
        acc(1'b1, errrec_pkg::ID_CTL, 64'h005, d);
        settle();
        chk(fault_irq, 1'b0);
        acc(1'b1, errrec_pkg::ID_CTL, 64'h10d, d);
        settle();
        chk(fault_irq, 1'b1);
        acc(1'b1, errrec_pkg::ID_MISC0, misc(1'b0, 7'h7f, 1'b0, 7'h0, 32'h0), d);
        settle();
        chk(fault_irq, 1'b0);
        ev(errrec_pkg::KIND_CORR, 1'b0, 1'b1, 32'h1234);
        ev(errrec_pkg::KIND_CORR, 1'b1, 1'b0, 32'h5678);
        settle();
        chk(fault_irq, 1'b1);
        acc(1'b0, errrec_pkg::ID_MISC0, 64'h0, d);
        chk(d, misc(1'b1, 7'h0, 1'b0, 7'h1, 32'h1234));
        acc(1'b0, errrec_pkg::ID_ADDR, 64'h0, d);
        chk(d, 64'h8000_1234_5678_9abc);
        acc(1'b1, errrec_pkg::ID_MISC0, 64'h0, d);
    endtask : t_overflow

    task automatic t_disabled();
        logic [63:0] d;
        acc(1'b1, errrec_pkg::ID_CTL, 64'h00c, d);
        ev(errrec_pkg::KIND_UNCORR, 1'b0, 1'b1, 32'h1234);
        chk(recovery_irq, 1'b0);
        chk(fault_irq, 1'b0);
        ev(errrec_pkg::KIND_CORR, 1'b0, 1'b1, 32'h1234);
        acc(1'b0, errrec_pkg::ID_MISC0, 64'h0, d);
        chk(d, 64'h0);
    endtask : t_disabled

    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_access();
        t_events();
        t_overflow();
        t_disabled();
        print_verdict();
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        fail_count++;
        print_verdict();
    end
endmodule : error_record_registers_test
